// ==== design/flash_front_pkg.sv ====
// Shared opcodes, byte layouts, identification table and state types of the front end
package flash_front_pkg;
  // Opcodes, shifted in most significant bit first
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_ID       = 8'h9f;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0b;
  localparam logic [7:0] OP_PAGE_PROGRAM  = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE  = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE    = 8'hc7;
  localparam logic [7:0] OP_POWER_DOWN    = 8'hb9;
  localparam logic [7:0] OP_WAKE          = 8'hab;
  // Frame layout in whole bytes, opcode counted
  localparam logic [9:0] BYTES_OPCODE_ONLY = 10'h001;
  localparam logic [9:0] BYTES_STATUS_WR   = 10'h002;
  localparam logic [9:0] BYTES_ADDR_END    = 10'h004;
  localparam logic [9:0] BYTES_FAST_END    = 10'h005;
  localparam logic [9:0] BYTES_SIG_END     = 10'h004;
  localparam logic [9:0] BYTES_PROG_MIN    = 10'h005;
  localparam logic [9:0] BYTES_SAT         = 10'h3ff;
  // Identification readout: maker, type, capacity, length, custom bytes
  localparam logic [4:0]   ID_BYTES       = 5'h14;
  localparam logic [4:0]   ID_CUSTOM_BASE = 5'h04;
  localparam logic [7:0]   ID_MAKER       = 8'h5a; // Arbitrary value
  localparam logic [7:0]   ID_MEM_TYPE    = 8'h3c; // Arbitrary value
  localparam logic [7:0]   ID_CAPACITY    = 8'h71; // Arbitrary value
  localparam logic [7:0]   ID_LENGTH      = 8'h10;
  localparam logic [127:0] FACTORY_CUSTOM_BYTES = 128'h0;
  localparam logic [7:0]   SIGNATURE      = 8'h2e; // Arbitrary value
  // Sector map: 64 sectors of 64 KB, sector index in address bits 21:16
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_MSB = 21;
  localparam logic [2:0] PROTECT_NONE = 3'h0;

  typedef enum logic [2:0] {
    EXEC_NONE         = 3'b000,
    EXEC_PROGRAM      = 3'b001,
    EXEC_SECTOR_ERASE = 3'b010,
    EXEC_BULK_ERASE   = 3'b011,
    EXEC_STATUS_WRITE = 3'b100
  } exec_op_t;

  typedef enum logic [2:0] {
    PH_OPCODE   = 3'b000,
    PH_ADDR     = 3'b001,
    PH_DUMMY    = 3'b010,
    PH_DATA_IN  = 3'b011,
    PH_DATA_OUT = 3'b100,
    PH_IGNORE   = 3'b101
  } phase_t;

  // Frame record held after deselect for the system domain to read
  typedef struct packed {
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic [9:0]  byte_cnt;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data0;
  } frame_rec_t;
endpackage

// ==== design/serial_flash_command_front_end.sv ====
// Serial flash command front end: link-side decoder and system-side command execution
// Functional notes
// - All opcode, address and data bits travel most significant bit first.
// - First bit sampled on first rising clock after select falls; rest on rising edges.
// - Program takes 3 address bytes plus data; sector erase 3 address; bulk erase none.
// - Read takes 3 address bytes, no dummy, then streams data without end.
// - Fast read takes 3 address bytes and one dummy byte before streaming data.
// - Wake leaves power-down; after 3 dummy bytes signature repeats until deselect.
// - Read-type commands end cleanly on deselect after any output bit.
// - Write-type commands execute only if deselect lands on a byte boundary.
// - During internal cycles array accesses are ignored; the cycle runs on.
// - Valid write enable alone in its frame sets the write enable latch.
// - Valid write disable alone in its frame clears the write enable latch.
// - Latch clears at reset and on completing erase, program, status write, disable.
// - Identification gives maker, type, capacity, length, sixteen custom bytes: twenty.
// - Custom identification bytes are read-only constants, zero unless factory-set.
// - Identification opcode is not decoded while a program or erase cycle runs.
// - Output bits change on the falling serial clock edge.
// - Deselect stops output at once and the next frame starts fresh.
// - Sixty-four 64 KB sectors; sector index is address bits 21 to 16.
// - In deep power-down, status write, program and erase are ignored.
// - Bulk erase accepted only when all protect level bits are zero.
`timescale 1ns/1ps
module serial_flash_command_front_end (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_busy,
  input  wire logic                      i_cycle_done,
  input  wire logic [7:0]                i_status_bits,
  input  wire logic [2:0]                i_protect_level_bits,
  input  wire logic                      i_sclk,
  input  wire logic                      i_sel_n,
  input  wire logic                      i_serial_in_line,
  input  wire logic [7:0]                i_rd_data,
  output logic                           o_serial_out_line,
  output logic                           o_serial_out_oe_n,
  output logic [23:0]                    o_rd_addr,
  output logic [7:0]                     o_prog_byte,
  output logic [7:0]                     o_prog_offset,
  output logic                           o_prog_strobe,
  output logic                           o_write_enable_latch,
  output logic                           o_deep_power_down,
  output logic                           o_exec_start,
  output flash_front_pkg::exec_op_t      o_exec_op,
  output logic [23:0]                    o_exec_addr,
  output logic [5:0]                     o_exec_sector,
  output logic [7:0]                     o_status_wdata,
  output logic                           o_cmd_rejected
);

  // Link control state, cleared the moment select rises
  typedef struct packed {
    logic                    live;
    flash_front_pkg::phase_t phase;
    logic                    out_en;
    logic                    load;
    logic                    from_array;
    logic [7:0]              out_byte;
    logic [4:0]              id_idx;
    logic [23:0]             rd_addr;
    logic [7:0]              prog_byte;
    logic [7:0]              prog_offset;
    logic                    prog_strobe;
    logic [9:0]              sync1;
    logic [9:0]              sync2;
  } link_t;

  // Falling-edge output stage
  typedef struct packed {
    logic [7:0] sr;
    logic       line;
    logic       oe_n;
  } drive_t;

  // System-domain state
  typedef struct packed {
    logic                      sel1;
    logic                      sel2;
    logic                      sel3;
    logic                      write_enable_latch;
    logic                      dpd;
    logic                      busy_tx;
    logic [7:0]                status_tx;
    logic                      start;
    flash_front_pkg::exec_op_t op;
    logic [23:0]               addr;
    logic [7:0]                wdata;
    logic                      rejected;
  } sys_t;

  link_t                   lnk;
  link_t                   next_lnk;
  flash_front_pkg::frame_rec_t rec;
  flash_front_pkg::frame_rec_t next_rec;
  drive_t                  drv;
  drive_t                  next_drv;
  sys_t                    sys;
  sys_t                    next_sys;

  // Saturating byte counter; long program frames must not wrap to a legal count
  function automatic logic [9:0] sat_inc(input logic [9:0] v);
    sat_inc = (v == flash_front_pkg::BYTES_SAT) ? v : v + 10'h001;
  endfunction

  // Identification byte by position, zero past the end
  function automatic logic [7:0] id_byte(input logic [4:0] idx);
    logic [127:0] sh;
    sh = '0;
    if (idx == 5'h00) begin
      id_byte = flash_front_pkg::ID_MAKER;
    end else if (idx == 5'h01) begin
      id_byte = flash_front_pkg::ID_MEM_TYPE;
    end else if (idx == 5'h02) begin
      id_byte = flash_front_pkg::ID_CAPACITY;
    end else if (idx == 5'h03) begin
      id_byte = flash_front_pkg::ID_LENGTH;
    end else if (idx < flash_front_pkg::ID_BYTES) begin
      // Fixed table, never writable from the link
      sh = flash_front_pkg::FACTORY_CUSTOM_BYTES >>
           {(flash_front_pkg::ID_BYTES - 5'h01 - idx), 3'b000};
      id_byte = sh[7:0];
    end else begin
      id_byte = 8'h00;
    end
  endfunction

  // Synchronised system view inside the link domain
  logic       busy_s;
  logic       dpd_s;
  logic [7:0] status_s;
  assign busy_s   = lnk.sync2[9];
  assign dpd_s    = lnk.sync2[8];
  assign status_s = lnk.sync2[7:0];

  // Link-side decode on rising serial clock
  always_comb begin
    logic [7:0] sh;
    logic [9:0] nbytes;
    flash_front_pkg::frame_rec_t cr;
    sh       = '0;
    nbytes   = '0;
    cr       = rec;
    // First edge of a frame restarts the counts
    if (!lnk.live) begin
      cr.bit_cnt  = 3'h0;
      cr.byte_cnt = 10'h000;
    end
    next_rec = cr;
    next_lnk = lnk;
    next_lnk.live        = 1'b1;
    next_lnk.sync1       = {sys.busy_tx, sys.dpd, sys.status_tx};
    next_lnk.sync2       = lnk.sync1;
    next_lnk.load        = 1'b0;
    next_lnk.prog_strobe = 1'b0;
    sh = {cr.shift[6:0], i_serial_in_line};
    next_rec.shift   = sh;
    next_rec.bit_cnt = cr.bit_cnt + 3'h1;
    if (cr.bit_cnt == 3'h7) begin
      nbytes = sat_inc(cr.byte_cnt);
      next_rec.byte_cnt = nbytes;
      next_lnk.load = 1'b1;
      unique case (lnk.phase)
        flash_front_pkg::PH_OPCODE: begin
          next_rec.opcode = sh;
          unique case (sh)
            flash_front_pkg::OP_READ,
            flash_front_pkg::OP_FAST_READ: begin
              // Array reads are dropped while an internal cycle runs
              next_lnk.phase = busy_s ? flash_front_pkg::PH_IGNORE
                                      : flash_front_pkg::PH_ADDR;
            end
            flash_front_pkg::OP_PAGE_PROGRAM,
            flash_front_pkg::OP_SECTOR_ERASE: begin
              next_lnk.phase = flash_front_pkg::PH_ADDR;
            end
            flash_front_pkg::OP_READ_STATUS: begin
              next_lnk.phase    = flash_front_pkg::PH_DATA_OUT;
              next_lnk.out_en   = 1'b1;
              next_lnk.out_byte = status_s;
            end
            flash_front_pkg::OP_READ_ID: begin
              if (busy_s) begin
                next_lnk.phase = flash_front_pkg::PH_IGNORE;
              end else begin
                next_lnk.phase    = flash_front_pkg::PH_DATA_OUT;
                next_lnk.out_en   = 1'b1;
                next_lnk.id_idx   = 5'h00;
                next_lnk.out_byte = id_byte(5'h00);
              end
            end
            flash_front_pkg::OP_WAKE: begin
              next_lnk.phase = flash_front_pkg::PH_DUMMY;
            end
            flash_front_pkg::OP_WRITE_STATUS,
            flash_front_pkg::OP_WRITE_ENABLE,
            flash_front_pkg::OP_WRITE_DISABLE,
            flash_front_pkg::OP_BULK_ERASE,
            flash_front_pkg::OP_POWER_DOWN: begin
              // Extra bytes are counted and fail the length check later
              next_lnk.phase = flash_front_pkg::PH_DATA_IN;
            end
            default: begin
              next_lnk.phase = flash_front_pkg::PH_IGNORE;
            end
          endcase
        end
        flash_front_pkg::PH_ADDR: begin
          next_rec.addr    = {cr.addr[15:0], sh};
          next_lnk.rd_addr = {cr.addr[15:0], sh};
          if (nbytes == flash_front_pkg::BYTES_ADDR_END) begin
            if (cr.opcode == flash_front_pkg::OP_READ) begin
              next_lnk.phase      = flash_front_pkg::PH_DATA_OUT;
              next_lnk.out_en     = 1'b1;
              next_lnk.from_array = 1'b1;
            end else if (cr.opcode == flash_front_pkg::OP_FAST_READ) begin
              next_lnk.phase = flash_front_pkg::PH_DUMMY;
            end else begin
              next_lnk.phase = flash_front_pkg::PH_DATA_IN;
            end
          end
        end
        flash_front_pkg::PH_DUMMY: begin
          if (cr.opcode == flash_front_pkg::OP_FAST_READ &&
              nbytes == flash_front_pkg::BYTES_FAST_END) begin
            next_lnk.phase      = flash_front_pkg::PH_DATA_OUT;
            next_lnk.out_en     = 1'b1;
            next_lnk.from_array = 1'b1;
          end else if (cr.opcode == flash_front_pkg::OP_WAKE &&
                       nbytes == flash_front_pkg::BYTES_SIG_END) begin
            next_lnk.phase    = flash_front_pkg::PH_DATA_OUT;
            next_lnk.out_en   = 1'b1;
            next_lnk.out_byte = flash_front_pkg::SIGNATURE;
          end
        end
        flash_front_pkg::PH_DATA_IN: begin
          if (nbytes == flash_front_pkg::BYTES_STATUS_WR) begin
            next_rec.data0 = sh;
          end
          // Page data goes out as it arrives, offset wraps inside the page
          if (cr.opcode == flash_front_pkg::OP_PAGE_PROGRAM && sys_ok_link()) begin
            next_lnk.prog_byte   = sh;
            next_lnk.prog_offset = cr.addr[7:0] + cr.byte_cnt[7:0] + 8'hfc;
            next_lnk.prog_strobe = 1'b1;
          end
        end
        flash_front_pkg::PH_DATA_OUT: begin
          if (lnk.from_array) begin
            next_lnk.rd_addr = lnk.rd_addr + 24'h000001;
          end else if (cr.opcode == flash_front_pkg::OP_READ_ID) begin
            next_lnk.id_idx   = lnk.id_idx + 5'h01;
            next_lnk.out_byte = id_byte(lnk.id_idx + 5'h01);
          end else if (cr.opcode == flash_front_pkg::OP_READ_STATUS) begin
            next_lnk.out_byte = status_s;
          end
        end
        flash_front_pkg::PH_IGNORE: begin
          next_lnk.out_en = 1'b0;
        end
        default: begin
          next_lnk.phase = flash_front_pkg::PH_IGNORE;
        end
      endcase
    end
  end

  // Page data is only forwarded when the frame can still lead to a program
  function automatic logic sys_ok_link();
    sys_ok_link = lnk.sync2[1] && !busy_s && !dpd_s;
  endfunction

  // Control state cleared by select rising; clock may stand still outside frames
  always_ff @(posedge i_sclk or posedge i_sel_n) begin
    if (i_sel_n) begin
      lnk <= '0;
    end else begin
      lnk <= next_lnk;
    end
  end

  // Frame record survives deselect so the system side can read it stably
  always_ff @(posedge i_sclk) begin
    rec <= next_rec;
  end

  // Output shifter: load a fresh byte at each boundary, else shift
  always_comb begin
    logic [7:0] src;
    src      = lnk.from_array ? i_rd_data : lnk.out_byte;
    next_drv = drv;
    next_drv.oe_n = !lnk.out_en;
    if (lnk.out_en && lnk.load) begin
      next_drv.line = src[7];
      next_drv.sr   = {src[6:0], 1'b0};
    end else if (lnk.out_en) begin
      next_drv.line = drv.sr[7];
      next_drv.sr   = {drv.sr[6:0], 1'b0};
    end
  end

  // Falling-edge drive; deselect releases the line at once
  always_ff @(negedge i_sclk or posedge i_sel_n) begin
    if (i_sel_n) begin
      drv <= '{sr: 8'h00, line: 1'b0, oe_n: 1'b1};
    end else begin
      drv <= next_drv;
    end
  end

  // System side: execute at the synchronised end of frame
  always_comb begin
    logic frame_end;
    logic whole;
    logic may_write;
    frame_end = 1'b0;
    whole     = 1'b0;
    may_write = 1'b0;
    next_sys  = sys;
    next_sys.sel1      = i_sel_n;
    next_sys.sel2      = sys.sel1;
    next_sys.sel3      = sys.sel2;
    next_sys.busy_tx   = i_busy;
    next_sys.status_tx = {i_status_bits[7:2], sys.write_enable_latch, i_busy};
    next_sys.start     = 1'b0;
    next_sys.rejected  = 1'b0;
    frame_end = sys.sel2 && !sys.sel3;
    whole     = (rec.bit_cnt == 3'h0);
    // Writes need the latch, an idle engine and no power-down
    may_write = whole && sys.write_enable_latch && !i_busy && !sys.dpd;
    // Completion clears the latch; a set in the same cycle wins
    if (i_cycle_done) begin
      next_sys.write_enable_latch = 1'b0;
    end
    if (frame_end) begin
      unique case (rec.opcode)
        flash_front_pkg::OP_WRITE_ENABLE: begin
          if (whole && rec.byte_cnt == flash_front_pkg::BYTES_OPCODE_ONLY) begin
            next_sys.write_enable_latch = 1'b1;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        flash_front_pkg::OP_WRITE_DISABLE: begin
          if (whole && rec.byte_cnt == flash_front_pkg::BYTES_OPCODE_ONLY) begin
            next_sys.write_enable_latch = 1'b0;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        flash_front_pkg::OP_POWER_DOWN: begin
          if (whole && rec.byte_cnt == flash_front_pkg::BYTES_OPCODE_ONLY && !i_busy) begin
            next_sys.dpd = 1'b1;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        flash_front_pkg::OP_WAKE: begin
          next_sys.dpd = 1'b0;
        end
        flash_front_pkg::OP_WRITE_STATUS: begin
          if (may_write && rec.byte_cnt == flash_front_pkg::BYTES_STATUS_WR) begin
            next_sys.start = 1'b1;
            next_sys.op    = flash_front_pkg::EXEC_STATUS_WRITE;
            next_sys.wdata = rec.data0;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        flash_front_pkg::OP_PAGE_PROGRAM: begin
          if (may_write && rec.byte_cnt >= flash_front_pkg::BYTES_PROG_MIN) begin
            next_sys.start = 1'b1;
            next_sys.op    = flash_front_pkg::EXEC_PROGRAM;
            next_sys.addr  = rec.addr;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        flash_front_pkg::OP_SECTOR_ERASE: begin
          if (may_write && rec.byte_cnt == flash_front_pkg::BYTES_ADDR_END) begin
            next_sys.start = 1'b1;
            next_sys.op    = flash_front_pkg::EXEC_SECTOR_ERASE;
            next_sys.addr  = rec.addr;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        flash_front_pkg::OP_BULK_ERASE: begin
          if (may_write && rec.byte_cnt == flash_front_pkg::BYTES_OPCODE_ONLY &&
              i_protect_level_bits == flash_front_pkg::PROTECT_NONE) begin
            next_sys.start = 1'b1;
            next_sys.op    = flash_front_pkg::EXEC_BULK_ERASE;
            next_sys.addr  = 24'h000000;
          end else begin
            next_sys.rejected = 1'b1;
          end
        end
        default: begin
          // Read-type frames may end on any bit and execute nothing
          next_sys.start = 1'b0;
        end
      endcase
    end
  end

  // Power-up state: latch clear, select seen high so no false frame end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sys <= '{sel1: 1'b1, sel2: 1'b1, sel3: 1'b1, write_enable_latch: 1'b0, dpd: 1'b0,
               busy_tx: 1'b0, status_tx: 8'h00, start: 1'b0,
               op: flash_front_pkg::EXEC_NONE, addr: 24'h000000,
               wdata: 8'h00, rejected: 1'b0};
    end else begin
      sys <= next_sys;
    end
  end

  // Ports straight from flip-flops
  assign o_serial_out_line    = drv.line;
  assign o_serial_out_oe_n    = drv.oe_n;
  assign o_rd_addr            = lnk.rd_addr;
  assign o_prog_byte          = lnk.prog_byte;
  assign o_prog_offset        = lnk.prog_offset;
  assign o_prog_strobe        = lnk.prog_strobe;
  assign o_write_enable_latch = sys.write_enable_latch;
  assign o_deep_power_down    = sys.dpd;
  assign o_exec_start         = sys.start;
  assign o_exec_op            = sys.op;
  assign o_exec_addr          = sys.addr;
  assign o_exec_sector        = sys.addr[flash_front_pkg::SECTOR_MSB:flash_front_pkg::SECTOR_LSB];
  assign o_status_wdata       = sys.wdata;
  assign o_cmd_rejected       = sys.rejected;

endmodule

// ==== tb/spi_host_model.sv ====
// Host controller model: drives select, clock and data in frames
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_out,
  input  wire logic i_oe_n,
  output logic      o_sclk,
  output logic      o_sel_n,
  output logic      o_din
);
  int   driven;
  logic last_bit;
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_din = 1'b0;
  end
  // Clock only inside frames; bits left aligned, first bit is the msb
  task automatic frame(input int n, input logic [255:0] tx, output logic [255:0] rx);
    rx = '0;
    driven = 0;
    last_bit = 1'b0;
    o_sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_din = tx[255-i];
      #16 o_sclk = 1'b1;
      // Undriven line shows the inverse of the last bit, never a held value
      rx[255-i] = (i_oe_n === 1'b0) ? i_out : ~last_bit;
      last_bit = rx[255-i];
      if (i_oe_n === 1'b0) driven++;
      #16 o_sclk = 1'b0;
    end
    #16 o_sel_n = 1'b1;
    o_din = ~o_din;
    #600;
  endtask
endmodule

// ==== tb/serial_flash_command_front_end_asserts.sv ====
// Checker on the front end ports
`timescale 1ns/1ps
module serial_flash_command_front_end_asserts (
  input wire logic                 i_ref_clk,
  input wire logic                 i_sys_rst,
  input wire logic                 i_busy,
  input wire logic                 i_cycle_done,
  input wire logic [2:0]           i_protect_level_bits,
  input wire logic                 i_sel_n,
  input wire logic                 o_serial_out_oe_n,
  input wire logic                 o_write_enable_latch,
  input wire logic                 o_deep_power_down,
  input wire logic                 o_exec_start,
  input wire flash_front_pkg::exec_op_t o_exec_op,
  input wire logic [23:0]          o_exec_addr,
  input wire logic [5:0]           o_exec_sector,
  input wire logic                 o_cmd_rejected
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  // Select held high over two samples
  sequence s_deselected;
    i_sel_n [*2];
  endsequence
  property p_start_pulse; o_exec_start |=> !o_exec_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_rej_pulse; o_cmd_rejected |=> !o_cmd_rejected; endproperty
  a_rej_pulse: assert property (p_rej_pulse) else $error("reject too long");
  property p_excl; !(o_exec_start && o_cmd_rejected); endproperty
  a_excl: assert property (p_excl) else $error("start and reject together");
  property p_sector; o_exec_sector == o_exec_addr[21:16]; endproperty
  a_sector: assert property (p_sector) else $error("sector field wrong");
  property p_quiet; s_deselected |-> o_serial_out_oe_n; endproperty
  a_quiet: assert property (p_quiet) else $error("output driven while idle");
  property p_latch; o_exec_start |-> $past(o_write_enable_latch); endproperty
  a_latch: assert property (p_latch) else $error("start without latch");
  property p_busy; o_exec_start |-> !$past(i_busy); endproperty
  a_busy: assert property (p_busy) else $error("start while busy");
  property p_prot;
    o_exec_start && o_exec_op == flash_front_pkg::EXEC_BULK_ERASE |->
      $past(i_protect_level_bits) == flash_front_pkg::PROTECT_NONE;
  endproperty
  a_prot: assert property (p_prot) else $error("bulk erase while protected");
  property p_awake; o_exec_start |-> !$past(o_deep_power_down); endproperty
  a_awake: assert property (p_awake) else $error("start in power-down");
  // Long idle so no frame end can set the latch in the same cycle
  property p_done; i_sel_n [*5] ##0 i_cycle_done |=> !o_write_enable_latch; endproperty
  a_done: assert property (p_done) else $error("latch kept after cycle end");
  property p_set;
    $rose(o_write_enable_latch) |-> i_sel_n && $past(i_sel_n) && $past(i_sel_n, 2);
  endproperty
  a_set: assert property (p_set) else $error("latch set inside a frame");
endmodule
bind serial_flash_command_front_end serial_flash_command_front_end_asserts chk_u (.*);

// ==== tb/serial_flash_command_front_end_bench.sv ====
// Bench for the serial flash command front end
`timescale 1ns/1ps
module serial_flash_command_front_end_bench;
  logic clk = 1'b0, rst = 1'b1, busy = 1'b0, done = 1'b0;
  logic [2:0] prot = 3'h0;
  logic [7:0] stat = 8'h80, pbyte, poff, wdata;
  logic sclk, sel_n, din, dout, oe_n, write_enable_latch, pd, start, rej, strobe;
  logic [23:0] rd_addr, ex_addr;
  logic [5:0] sector;
  flash_front_pkg::exec_op_t op;
  logic [255:0] rx;
  logic [15:0] pseen = 16'h0000;
  // Page data byte and its offset as the strobe rises
  always @(posedge strobe) pseen = {poff, pbyte};
  int num_errors = 0, checks = 0, cyc = 0, rejs = 0;
  wire logic [7:0] rdat = rd_addr[7:0] ^ 8'ha5; // Array model: byte is address xor a5
  always #50 clk = ~clk;
  serial_flash_command_front_end dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_busy(busy),
    .i_cycle_done(done), .i_status_bits(stat), .i_protect_level_bits(prot), .i_sclk(sclk),
    .i_sel_n(sel_n), .i_serial_in_line(din), .i_rd_data(rdat), .o_serial_out_line(dout),
    .o_serial_out_oe_n(oe_n), .o_rd_addr(rd_addr), .o_prog_byte(pbyte),
    .o_prog_offset(poff), .o_prog_strobe(strobe), .o_write_enable_latch(write_enable_latch),
    .o_deep_power_down(pd), .o_exec_start(start), .o_exec_op(op), .o_exec_addr(ex_addr),
    .o_exec_sector(sector), .o_status_wdata(wdata), .o_cmd_rejected(rej));
  spi_host_model host_u (.i_out(dout), .i_oe_n(oe_n), .o_sclk(sclk), .o_sel_n(sel_n),
    .o_din(din));
  // Reject pulses counted; hang cut short by a cycle ceiling
  always @(posedge clk) begin
    cyc++;
    if (rej === 1'b1) rejs++;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One frame of n bits, bits left aligned
  task automatic cmd(input int n, input logic [255:0] tx);
    host_u.frame(n, tx, rx);
  endtask
  task automatic pulse_done;
    @(negedge clk) done = 1'b1;
    @(negedge clk) done = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check("wel", write_enable_latch, 1'b0);
    check("op", op, flash_front_pkg::EXEC_NONE);
    cmd(8, {8'h06, 248'h0}); check("wel", write_enable_latch, 1'b1);
    cmd(8, {8'h04, 248'h0}); check("wel", write_enable_latch, 1'b0);
    cmd(9, {8'h06, 248'h0}); check("wel", write_enable_latch, 1'b0);
    cmd(8, {8'h06, 248'h0});
    cmd(32, {8'hd8, 24'h3f1234, 224'h0}); check("op", op, flash_front_pkg::EXEC_SECTOR_ERASE);
    check("sector", {sector, ex_addr}, {6'h3f, 24'h3f1234});
    pulse_done(); check("wel", write_enable_latch, 1'b0);
    @(negedge clk) busy = 1'b1;
    cmd(40, {8'h03, 24'h000010, 224'h0}); check("busy read", host_u.driven, 0);
    @(negedge clk) busy = 1'b0;
    cmd(48, {8'h03, 24'h0000fe, 224'h0}); check("read", rx[223:208], 16'h5b5a);
    cmd(48, {8'h0b, 24'h000020, 224'h0}); check("fast", rx[215:208], 8'h85);
    cmd(168, {8'h9f, 248'h0});
    check("id", rx[247:216], {flash_front_pkg::ID_MAKER, flash_front_pkg::ID_MEM_TYPE,
      flash_front_pkg::ID_CAPACITY, flash_front_pkg::ID_LENGTH});
    check("custom", rx[215:88], flash_front_pkg::FACTORY_CUSTOM_BYTES);
    cmd(12, {8'h9f, 248'h0});
    cmd(8, {8'h06, 248'h0});
    cmd(16, {8'h05, 248'h0}); check("status", rx[247:240], 8'h82);
    cmd(24, {8'hff, 8'h06, 240'h0}); check("unknown", host_u.driven, 0);
    @(negedge clk) prot = 3'h1;
    cmd(8, {8'hc7, 248'h0}); check("op", op, flash_front_pkg::EXEC_SECTOR_ERASE);
    @(negedge clk) prot = 3'h0;
    cmd(8, {8'hc7, 248'h0}); check("op", op, flash_front_pkg::EXEC_BULK_ERASE);
    cmd(8, {8'hb9, 248'h0}); check("pd", pd, 1'b1);
    cmd(16, {8'h01, 8'h9c, 240'h0}); check("op", op, flash_front_pkg::EXEC_BULK_ERASE);
    cmd(40, {8'hab, 248'h0}); check("sig", rx[223:216], flash_front_pkg::SIGNATURE);
    check("pd", pd, 1'b0);
    cmd(16, {8'h01, 8'h9c, 240'h0}); check("wr", {op, wdata}, {3'h4, 8'h9c});
    pulse_done();
    cmd(8, {8'h06, 248'h0});
    cmd(40, {8'h02, 24'h000105, 8'h3c, 216'h0}); check("pp", {op, ex_addr}, {3'h1, 24'h105});
    check("prog data", pseen, 16'h053c);
    check("rejects", rejs, 3);
    end_of_test();
  end
endmodule
